/* rtl/sei_core.sv */
// serial peripheral core with error detection, interrupt requests and partial reset
`timescale 1ns/1ps
module sei_core #(
  parameter int W        = sei_pkg::DATA_W,
  parameter int HALF_DIV = sei_pkg::MASTER_HALF_DIV
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         ce,
  // control inputs, held by software
  input  wire logic         enable_set,
  input  wire logic         enable_clear,
  input  wire logic         master_select_bit,
  input  wire logic         cpol,
  input  wire logic         cpha,
  input  wire logic         mode_fault_enable,
  input  wire logic         error_irq_enable,
  input  wire logic         transmit_irq_enable,
  input  wire logic         receive_irq_enable,
  // cpu access strobes
  input  wire logic         status_read,
  input  wire logic         control_write,
  input  wire logic         data_read,
  input  wire logic         data_write,
  input  wire logic [W-1:0] data_wdata,
  // serial pins
  input  wire logic         serial_clock_in,
  input  wire logic         mosi_in,
  input  wire logic         miso_in,
  input  wire logic         select_n_in,
  output logic              serial_clock_out,
  output logic              serial_clock_oe_n,
  output logic              mosi_out,
  output logic              mosi_oe_n,
  output logic              miso_out,
  output logic              miso_oe_n,
  // status and requests
  output logic              module_enable_bit,
  output logic [W-1:0]      data_rdata,
  output logic              transmit_empty_flag,
  output logic              receive_full_flag,
  output logic              receive_overrun_flag,
  output logic              mode_fault_flag,
  output logic              transmit_irq,
  output logic              receive_error_irq
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic sel_n_s;
  logic sck_s;
  logic mosi_s;
  logic miso_s;

  // select idles high, the other pins low, so reset makes no false edge
  localparam int         N_PINS    = 4;
  localparam logic [3:0] SYNC_INIT = 4'h8;
  logic [3:0] pin_raw;
  logic [3:0] pin_lvl;

  assign pin_raw = {select_n_in, serial_clock_in, mosi_in, miso_in};
  for (genvar i = 0; i < N_PINS; i++) begin : g_sync
    sei_pin_sync #(.INIT(SYNC_INIT[i])) u_sync (
      .mclk   (mclk),
      .resetn (resetn),
      .ce     (ce),
      .pin    (pin_raw[i]),
      .level  (pin_lvl[i])
    );
  end
  assign {sel_n_s, sck_s, mosi_s, miso_s} = pin_lvl;

  // ----------------------------------------------------------------
  // edge detection on synchronised levels
  // ----------------------------------------------------------------
  logic sel_n_prev_q;
  logic sck_prev_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sel_n_prev_q <= 1'b1;
      sck_prev_q   <= 1'b0;
    end else if (ce) begin
      sel_n_prev_q <= sel_n_s;
      sck_prev_q   <= sck_s;
    end
  end

  wire sel_fall = sel_n_prev_q & ~sel_n_s;
  wire sel_rise = ~sel_n_prev_q & sel_n_s;
  wire sck_edge = sck_prev_q ^ sck_s;

  // ----------------------------------------------------------------
  // transfer sequencing
  // ----------------------------------------------------------------
  sei_pkg::sei_state_type state_q;
  logic         tx_pending_q;
  logic [W-1:0] txd_q;
  logic [W-1:0] rxd_q;
  logic         sck_gen_q;
  logic [7:0]   div_q;
  logic         status_seen_ovr_q;
  logic         status_seen_mode_fault_flag_q;
  logic         mst_edge;
  logic         sample;
  logic         shift;
  logic         in_bit;
  logic         master_fault;
  logic         slave_fault;
  logic         sh_load;
  logic [W-1:0] sh_data;

  wire is_master  = master_select_bit;
  wire slave_sel  = ~is_master & ~sel_n_s;
  wire active     = (state_q != sei_pkg::SEI_IDLE);
  // even edge count within the byte is the leading edge of a bit
  function automatic logic lead_edge(input logic [3:0] edges);
    lead_edge = ~edges[0];
  endfunction

  logic [3:0] edge_cnt_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_q <= 8'h00;
    end else if (ce) begin
      if (!module_enable_bit || !is_master || state_q != sei_pkg::SEI_XFER) begin
        div_q <= 8'h00;
      end else if (div_q == 8'(HALF_DIV - 1)) begin
        div_q <= 8'h00;
      end else begin
        div_q <= div_q + 8'h01;
      end
    end
  end

  assign mst_edge = module_enable_bit & is_master & (state_q == sei_pkg::SEI_XFER) &
                    (div_q == 8'(HALF_DIV - 1));

  // edges are counted per byte; with cpha 0 sampling happens on the leading edge
  logic any_edge;
  assign any_edge = is_master ? mst_edge : (slave_sel & sck_edge & active);
  assign sample   = any_edge & (lead_edge(edge_cnt_q) ^ cpha);
  // cpha 1: the first edge only starts the byte, and the last capture is pushed in at once,
  // otherwise the byte would end one bit short
  localparam logic [3:0] LAST_EDGE = 4'(2 * sei_pkg::BITS_PER_BYTE - 1);
  assign shift    = any_edge & ((~(lead_edge(edge_cnt_q) ^ cpha) & (edge_cnt_q != 4'h0)) |
                                (sample & cpha & (edge_cnt_q == LAST_EDGE)));
  assign in_bit   = is_master ? miso_s : mosi_s;

  // a disabled master ignores its select pin
  assign master_fault = is_master & module_enable_bit & mode_fault_enable & sel_fall;
  assign slave_fault  = ~is_master & mode_fault_enable & sel_rise & active;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q    <= sei_pkg::SEI_IDLE;
      edge_cnt_q <= 4'h0;
    end else if (ce) begin
      if (!module_enable_bit || master_fault) begin
        state_q    <= sei_pkg::SEI_IDLE;
        edge_cnt_q <= 4'h0;
      end else begin
        case (state_q)
          sei_pkg::SEI_IDLE: begin
            edge_cnt_q <= 4'h0;
            if (is_master && tx_pending_q) begin
              state_q <= sei_pkg::SEI_XFER;
            end else if (!is_master && !cpha && sel_fall) begin
              state_q <= sei_pkg::SEI_XFER;
            end else if (!is_master && cpha && slave_sel && sck_edge) begin
              state_q    <= sei_pkg::SEI_XFER;
              edge_cnt_q <= 4'h1;
            end
          end
          sei_pkg::SEI_XFER: begin
            if (!is_master && sel_n_s) begin
              state_q <= sei_pkg::SEI_IDLE;
            end else if (any_edge) begin
              edge_cnt_q <= edge_cnt_q + 4'h1;
              if (edge_cnt_q == 4'(2 * sei_pkg::BITS_PER_BYTE - 1)) begin
                state_q <= sei_pkg::SEI_TAIL;
              end
            end
          end
          sei_pkg::SEI_TAIL: begin
            edge_cnt_q <= 4'h0;
            state_q    <= sei_pkg::SEI_IDLE;
          end
          default: begin
            state_q <= sei_pkg::SEI_IDLE;
          end
        endcase
      end
    end
  end

  wire byte_end = (state_q == sei_pkg::SEI_TAIL);

  // ----------------------------------------------------------------
  // shifter and data registers
  // ----------------------------------------------------------------
  assign sh_load = module_enable_bit & tx_pending_q & (state_q == sei_pkg::SEI_IDLE);

  sei_shift #(.W(W)) u_shift (
    .mclk      (mclk),
    .resetn    (resetn),
    .ce        (ce),
    .clr       (~module_enable_bit | master_fault),
    .load      (sh_load),
    .load_data (txd_q),
    .sample    (sample),
    .shift     (shift),
    .in_bit    (in_bit),
    .data      (sh_data),
    .cnt       ()
  );

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      txd_q        <= sei_pkg::TXD_RESET;
      tx_pending_q <= 1'b0;
    end else if (ce) begin
      if (!module_enable_bit || master_fault) begin
        tx_pending_q <= 1'b0;
      end else if (data_write) begin
        txd_q        <= data_wdata;
        tx_pending_q <= 1'b1;
      end else if (sh_load) begin
        tx_pending_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      transmit_empty_flag <= 1'b1;
    end else if (ce) begin
      if (!module_enable_bit || master_fault || sh_load) begin
        transmit_empty_flag <= 1'b1;
      end else if (data_write) begin
        transmit_empty_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive flags; cleared only by system reset or the cpu sequences
  // ----------------------------------------------------------------
  // two edges per bit, so the capture index is the edge count halved; it restarts every byte,
  // unlike the shifter's own count, which only a load, a disable or a master fault clears
  wire ovr_hit = active & sample & (edge_cnt_q[3:1] == 3'(sei_pkg::OVR_CHECK_BIT - 4'h1)) &
                 receive_full_flag;
  wire rx_move = byte_end & ~receive_overrun_flag & ~ovr_hit;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rxd_q             <= sei_pkg::RXD_RESET;
      receive_full_flag <= 1'b0;
      data_rdata        <= sei_pkg::RXD_RESET;
    end else if (ce) begin
      if (rx_move) begin
        rxd_q             <= sh_data;
        receive_full_flag <= 1'b1;
      end else if (data_read && status_seen_ovr_q) begin
        receive_full_flag <= 1'b0;
      end
      data_rdata <= rx_move ? sh_data : rxd_q;
    end
  end

  // status read arms the clears; the arm is taken at the read itself
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      status_seen_ovr_q  <= 1'b0;
      status_seen_mode_fault_flag_q <= 1'b0;
    end else if (ce) begin
      if (status_read) begin
        status_seen_ovr_q  <= 1'b1;
        status_seen_mode_fault_flag_q <= mode_fault_flag;
      end else begin
        if (data_read) begin
          status_seen_ovr_q <= 1'b0;
        end
        if (control_write || master_fault || slave_fault) begin
          status_seen_mode_fault_flag_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      receive_overrun_flag <= 1'b0;
    end else if (ce) begin
      if (ovr_hit) begin
        receive_overrun_flag <= 1'b1;
      end else if (data_read && status_seen_ovr_q) begin
        receive_overrun_flag <= 1'b0;
      end
    end
  end

  // set wins; a fault present during the sequence blocks the clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_fault_flag <= 1'b0;
    end else if (ce) begin
      if (master_fault || slave_fault) begin
        mode_fault_flag <= 1'b1;
      end else if (control_write && status_seen_mode_fault_flag_q) begin
        mode_fault_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // module enable; master_select_bit is never touched here
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      module_enable_bit <= 1'b0;
    end else if (ce) begin
      if (master_fault || enable_clear) begin
        module_enable_bit <= 1'b0;
      end else if (enable_set) begin
        module_enable_bit <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // pins and requests
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sck_gen_q <= 1'b0;
    end else if (ce) begin
      if (state_q != sei_pkg::SEI_XFER) begin
        sck_gen_q <= 1'b0;
      end else if (mst_edge) begin
        sck_gen_q <= ~sck_gen_q;
      end
    end
  end

  wire drive_m = module_enable_bit & is_master & ~master_fault;
  wire drive_s = module_enable_bit & slave_sel;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      serial_clock_out  <= 1'b0;
      serial_clock_oe_n <= 1'b1;
      mosi_out          <= 1'b0;
      mosi_oe_n         <= 1'b1;
      miso_out          <= 1'b0;
      miso_oe_n         <= 1'b1;
    end else if (ce) begin
      serial_clock_out  <= cpol ^ sck_gen_q;
      serial_clock_oe_n <= ~drive_m;
      mosi_out          <= sh_data[W-1];
      mosi_oe_n         <= ~drive_m;
      miso_out          <= sh_data[W-1];
      miso_oe_n         <= ~drive_s;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      transmit_irq      <= 1'b0;
      receive_error_irq <= 1'b0;
    end else if (ce) begin
      transmit_irq      <= transmit_empty_flag & transmit_irq_enable & module_enable_bit;
      receive_error_irq <= (receive_full_flag & receive_irq_enable & module_enable_bit) |
                           ((mode_fault_flag | receive_overrun_flag) & error_irq_enable);
    end
  end
endmodule

/* rtl/sei_pin_sync.sv */
// three flop input synchroniser; a level is accepted once stages two and three agree
`timescale 1ns/1ps
module sei_pin_sync #(
  parameter logic INIT = 1'b0
) (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic ce,
  input  wire logic pin,
  output logic      level
);
  logic [2:0] sync_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync_q <= {3{INIT}};
    end else if (ce) begin
      sync_q <= {sync_q[1:0], pin};
    end
  end

  // first stage only feeds the second
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      level <= INIT;
    end else if (ce && (sync_q[1] == sync_q[2])) begin
      level <= sync_q[2];
    end
  end
endmodule

/* rtl/sei_pkg.sv */
// constants shared by the serial error/interrupt/reset block
package sei_pkg;
  localparam int DATA_W      = 8;
  localparam int BIT_CNT_W   = 4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // the overrun check happens on the capture of the second bit (bit index 1 counted from zero)
  localparam logic [3:0] OVR_CHECK_BIT = 4'h2;
  localparam logic [7:0] SHIFT_RESET   = 8'h00;
  localparam logic [7:0] TXD_RESET     = 8'h00;
  localparam logic [7:0] RXD_RESET     = 8'h00;
  localparam logic [3:0] CNT_RESET     = 4'h0;
  localparam int MASTER_HALF_DIV = 4;
  localparam int SYNC_STAGES     = 3;
  typedef enum logic [1:0] {
    SEI_IDLE,
    SEI_XFER,
    SEI_TAIL
  } sei_state_type;
endpackage

/* rtl/sei_shift.sv */
// eight bit shift register with bit counter; cleared while the module is off
`timescale 1ns/1ps
module sei_shift #(
  parameter int W = sei_pkg::DATA_W
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         ce,
  input  wire logic         clr,
  input  wire logic         load,
  input  wire logic [W-1:0] load_data,
  input  wire logic         sample,
  input  wire logic         shift,
  input  wire logic         in_bit,
  output logic [W-1:0]      data,
  output logic [3:0]        cnt
);
  logic in_hold_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      data      <= sei_pkg::SHIFT_RESET;
      cnt       <= sei_pkg::CNT_RESET;
      in_hold_q <= 1'b0;
    end else if (ce) begin
      if (clr) begin
        data <= sei_pkg::SHIFT_RESET;
        cnt  <= sei_pkg::CNT_RESET;
      end else if (load) begin
        data <= load_data;
        cnt  <= sei_pkg::CNT_RESET;
      end else begin
        if (sample) begin
          in_hold_q <= in_bit;
          cnt       <= cnt + 4'h1;
        end
        if (shift) begin
          data <= {data[W-2:0], sample ? in_bit : in_hold_q};
        end
      end
    end
  end
endmodule

/* tb/sei_core_properties.sv */
// port level assertions for the serial error and interrupt core
`timescale 1ns/1ps
module sei_core_properties #(
  parameter int W        = sei_pkg::DATA_W,
  parameter int HALF_DIV = sei_pkg::MASTER_HALF_DIV
) (
  input wire logic         mclk,
  input wire logic         resetn,
  input wire logic         master_select_bit,
  input wire logic         mode_fault_enable,
  input wire logic         error_irq_enable,
  input wire logic         transmit_irq_enable,
  input wire logic         receive_irq_enable,
  input wire logic         control_write,
  input wire logic         data_read,
  input wire logic         select_n_in,
  input wire logic         serial_clock_oe_n,
  input wire logic         mosi_oe_n,
  input wire logic         miso_oe_n,
  input wire logic         module_enable_bit,
  input wire logic [W-1:0] data_rdata,
  input wire logic         transmit_empty_flag,
  input wire logic         receive_full_flag,
  input wire logic         receive_overrun_flag,
  input wire logic         mode_fault_flag,
  input wire logic         transmit_irq,
  input wire logic         receive_error_irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // requests
  // ----------------------------------------
  chk_tx_irq_on: assert property (
    (transmit_empty_flag && transmit_irq_enable && module_enable_bit)[*2] |-> transmit_irq)
    else $error("tx request missing");
  chk_rx_irq_on: assert property (
    (receive_full_flag && receive_irq_enable && module_enable_bit)[*2] |-> receive_error_irq)
    else $error("rx request missing");
  chk_err_irq_on: assert property (
    ((receive_overrun_flag || mode_fault_flag) && error_irq_enable)[*2] |-> receive_error_irq)
    else $error("error request missing");
  chk_irq_quiet: assert property (
    (!error_irq_enable && !receive_irq_enable)[*2] |-> !receive_error_irq)
    else $error("rx/error request without enable");
  // ----------------------------------------
  // pins and partial reset
  // ----------------------------------------
  chk_off_release: assert property (
    (!module_enable_bit)[*2] |-> transmit_empty_flag && serial_clock_oe_n && mosi_oe_n && miso_oe_n)
    else $error("disabled core not released");
  chk_master_dir: assert property (
    (module_enable_bit && master_select_bit)[*3] |-> !serial_clock_oe_n && !mosi_oe_n && miso_oe_n)
    else $error("master pin directions wrong");
  chk_desel_float: assert property (
    (!master_select_bit && select_n_in)[*6] |-> miso_oe_n)
    else $error("deselected slave drives miso");
  // ----------------------------------------
  // fault and overrun flags
  // ----------------------------------------
  chk_mf_gate: assert property (
    ((!mode_fault_enable)[*6] ##0 !mode_fault_flag) |=> !mode_fault_flag)
    else $error("mode fault set while detection off");
  chk_mf_hold: assert property (
    mode_fault_flag && !control_write |=> mode_fault_flag)
    else $error("mode fault cleared without control write");
  chk_ovr_hold: assert property (
    receive_overrun_flag && !data_read |=> receive_overrun_flag && $stable(data_rdata))
    else $error("overrun lost or receive data changed");
  chk_master_fault: assert property (
    $rose(mode_fault_flag) && master_select_bit |-> !module_enable_bit && transmit_empty_flag)
    else $error("master fault did not shut down");
  chk_master_detect: assert property (
    master_select_bit && mode_fault_enable && module_enable_bit && $fell(select_n_in) |-> ##[1:6] mode_fault_flag)
    else $error("master select fall not flagged");
  chk_slave_keep: assert property (
    $rose(mode_fault_flag) && !master_select_bit |-> module_enable_bit)
    else $error("slave fault cleared enable");
endmodule

bind sei_core sei_core_properties #(.W(W), .HALF_DIV(HALF_DIV)) u_sei_core_properties (
  .mclk, .resetn, .master_select_bit, .mode_fault_enable, .error_irq_enable,
  .transmit_irq_enable, .receive_irq_enable, .control_write, .data_read, .select_n_in,
  .serial_clock_oe_n, .mosi_oe_n, .miso_oe_n, .module_enable_bit, .data_rdata,
  .transmit_empty_flag, .receive_full_flag, .receive_overrun_flag, .mode_fault_flag,
  .transmit_irq, .receive_error_irq
);

/* tb/sei_remote_master.sv */
// remote master model driving link clock, data and select of the slave
`timescale 1ns/1ps
module sei_remote_master (
  input  wire logic cpol,
  output logic      sclk,
  output logic      mosi,
  output logic      sel_n
);
  logic act;
  assign sclk = cpol ^ act;
  initial begin
    act = 1'b0;
    mosi = 1'b0;
    sel_n = 1'b1;
  end
  // msb first, 160 ns per bit; n of 0 gives a bare select pulse
  task automatic frame(input logic [7:0] b, input logic ph, input int n);
    #163 sel_n = 1'b0;
    #160;
    for (int i = 7; i > 7 - n; i--) begin
      if (ph) act = 1'b1;
      mosi = b[i];
      #80 act = ~act;
      #80 act = 1'b0;
    end
    #160 sel_n = 1'b1;
    // released line shows the inverse so a stale level cannot pass
    mosi = ~mosi;
  endtask
endmodule

/* tb/testbench.sv */
// self-checking bench for the serial error and interrupt core
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [7:0] b;
    logic       ph;
    logic       pol;
    logic [3:0] n;
    logic       full;
    logic       mf;
  } sei_row_type;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic [6:0]  cfg = 7'h00;
  logic [5:0]  stb = 6'h00;
  logic [7:0]  wdata = 8'h00;
  logic        miso_q = 1'b0;
  logic        sclk_out, sclk_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
  logic        en_bit, txe, rxf, ovr, mf, tx_irq, rx_irq;
  logic [7:0]  rdata;
  logic        p_sclk, p_mosi, sel_n, sclk_in, mosi_in, miso_in;
  int          err_total = 0;
  int          checks_done = 0;
  sei_row_type rows [6] = '{
    '{8'hA5, 1'b0, 1'b0, 4'h8, 1'b1, 1'b0},
    '{8'h3C, 1'b1, 1'b0, 4'h8, 1'b1, 1'b0},
    '{8'hC3, 1'b0, 1'b1, 4'h8, 1'b1, 1'b0},
    '{8'h5A, 1'b1, 1'b1, 4'h8, 1'b1, 1'b0},
    '{8'h00, 1'b0, 1'b0, 4'h0, 1'b0, 1'b1},
    '{8'h00, 1'b1, 1'b0, 4'h0, 1'b0, 1'b0}
  };
  always #10 mclk = ~mclk;
  // miso has no pull, so an undriven line shows the inverse of its last level
  always @(posedge mclk) if (!miso_oe_n) miso_q <= miso_out;
  assign miso_in = miso_oe_n ? ~miso_q : miso_out;
  assign sclk_in = sclk_oe_n ? p_sclk : sclk_out;
  assign mosi_in = mosi_oe_n ? p_mosi : mosi_out;
  sei_remote_master u_sei_remote_master (.cpol(cfg[1]), .sclk(p_sclk), .mosi(p_mosi), .sel_n(sel_n));
  sei_core u_sei_core (
    .mclk, .resetn, .ce(1'b1),
    .enable_set(stb[0]), .enable_clear(stb[1]), .status_read(stb[2]),
    .control_write(stb[3]), .data_read(stb[4]), .data_write(stb[5]), .data_wdata(wdata),
    .master_select_bit(cfg[0]), .cpol(cfg[1]), .cpha(cfg[2]), .mode_fault_enable(cfg[3]),
    .error_irq_enable(cfg[4]), .transmit_irq_enable(cfg[5]), .receive_irq_enable(cfg[6]),
    .serial_clock_in(sclk_in), .mosi_in(mosi_in), .miso_in(miso_in), .select_n_in(sel_n),
    .serial_clock_out(sclk_out), .serial_clock_oe_n(sclk_oe_n), .mosi_out(mosi_out),
    .mosi_oe_n(mosi_oe_n), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
    .module_enable_bit(en_bit), .data_rdata(rdata), .transmit_empty_flag(txe),
    .receive_full_flag(rxf), .receive_overrun_flag(ovr), .mode_fault_flag(mf),
    .transmit_irq(tx_irq), .receive_error_irq(rx_irq)
  );
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // strobe bits: 0 set, 1 clear, 2 status read, 3 control write, 4 data read, 5 data write
  task automatic pulse(input int i);
    @(posedge mclk) stb[i] <= 1'b1;
    @(posedge mclk) stb <= 6'h00;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    tally_and_finish;
  end
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    tick(1);
    chk({txe, en_bit}, 2'h2);
    chk({sclk_oe_n, mosi_oe_n, miso_oe_n}, 3'h7);
    chk({rxf, ovr, mf}, 3'h0);
    tick(2);
    @(posedge mclk) cfg <= 7'h78;
    tick(2);
    chk(tx_irq, 1'b0);
    pulse(0);
    tick(3);
    chk(tx_irq, 1'b1);
    foreach (rows[k]) begin
      pulse(1);
      @(posedge mclk) cfg[2:1] <= {rows[k].ph, rows[k].pol};
      tick(4);
      pulse(0);
      tick(6);
      u_sei_remote_master.frame(rows[k].b, rows[k].ph, rows[k].n);
      tick(8);
      chk(rxf, rows[k].full);
      chk(mf, rows[k].mf);
      chk(en_bit, 1'b1);
      chk(rx_irq, rows[k].full | rows[k].mf);
      if (rows[k].full) chk(rdata, rows[k].b);
      pulse(2);
      pulse(4);
      pulse(2);
      pulse(3);
      tick(2);
      chk({rxf, mf}, 2'h0);
    end
    @(posedge mclk) wdata <= 8'hC6;
    pulse(5);
    tick(4);
    chk(txe, 1'b1);
    u_sei_remote_master.frame(8'h96, 1'b1, 8);
    u_sei_remote_master.frame(8'h69, 1'b1, 8);
    tick(8);
    chk({ovr, rx_irq}, 2'h3);
    u_sei_remote_master.frame(8'h11, 1'b1, 8);
    tick(8);
    chk(rdata, 8'h96);
    chk(rxf, 1'b1);
    pulse(2);
    pulse(4);
    tick(2);
    chk({rxf, ovr}, 2'h0);
    pulse(1);
    @(posedge mclk) cfg <= 7'h71;
    pulse(0);
    tick(6);
    chk({sclk_oe_n, mosi_oe_n, miso_oe_n}, 3'h1);
    u_sei_remote_master.frame(8'h00, 1'b0, 0);
    tick(6);
    chk({en_bit, mf}, 2'h2);
    @(posedge mclk) cfg[3] <= 1'b1;
    u_sei_remote_master.frame(8'h00, 1'b0, 0);
    tick(2);
    chk({en_bit, txe, mf, rx_irq}, 4'h7);
    chk({sclk_oe_n, mosi_oe_n, miso_oe_n}, 3'h7);
    chk(tx_irq, 1'b0);
    @(posedge mclk) cfg[3] <= 1'b0;
    tick(4);
    chk(mf, 1'b1);
    pulse(2);
    pulse(3);
    tick(2);
    chk(mf, 1'b0);
    tally_and_finish;
  end
endmodule
